// [src/tvgl_defines.vh]
// register map, field positions, reset values and timing counts of the tv-out port
`ifndef TVGL_DEFINES_VH
`define TVGL_DEFINES_VH

// apb byte offsets
`define TVGL_ADDR_W 12
`define TVGL_OFS_FORMAT 12'h000
`define TVGL_OFS_HWIN 12'h004
`define TVGL_OFS_CTL 12'h008
`define TVGL_OFS_STATUS 12'h00C

// video_input_format_ctl fields
`define TVGL_FMT_TVOUT_BIT 16
`define TVGL_FMT_GENLOCK_BIT 18

// tv_out_hblank_window fields
`define TVGL_WIN_START_MSB 10
`define TVGL_WIN_START_LSB 0
`define TVGL_WIN_END_MSB 26
`define TVGL_WIN_END_LSB 16
`define TVGL_WIN_MASK 32'h07FF07FF

// tv_out_ctl fields
`define TVGL_CTL_IGNORE_TIMING_BIT 0
`define TVGL_CTL_SYNC_LOW_BIT 1
`define TVGL_CTL_ENC_RESETN_BIT 31
`define TVGL_CTL_MASK 32'h80000003

// tv_out_status fields
`define TVGL_STS_HCOUNT_MSB 10
`define TVGL_STS_HBLANKN_BIT 16
`define TVGL_STS_WINMODE_BIT 17
`define TVGL_STS_LINESYNC_BIT 18
`define TVGL_STS_FRAMESYNC_BIT 19

// reset values
`define TVGL_FORMAT_RST 32'h00000000
`define TVGL_HWIN_RST 32'h00000000
`define TVGL_CTL_RST 32'h00000000

// horizontal counter
`define TVGL_HCNT_W 11
`define TVGL_HCNT_MAX 11'h7FF

// timing: clock period and clock echo lag behind the sampled reference clock
`define TVGL_CLK_PERIOD_NS 4
`define TVGL_ECHO_DELAY_NS 16
`define TVGL_ECHO_DELAY_CYC ((`TVGL_ECHO_DELAY_NS + `TVGL_CLK_PERIOD_NS - 1) / `TVGL_CLK_PERIOD_NS)

`endif

// [src/tvgl_sync2.v]
// two flip-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/10ps
`default_nettype none

module tvgl_sync2 #(
  parameter W = 1
) (
  // clock and reset
  input wire clock,
  input wire resetn,
  // asynchronous level in, synchronised level out
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge clock) begin
    if (!resetn) begin
      meta <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// [src/tvgl_hwin.v]
// horizontal position counter and programmed horizontal blank window
`timescale 1ns/10ps
`default_nettype none
`include "tvgl_defines.vh"

module tvgl_hwin (
  // clock and reset
  input wire clock,
  input wire resetn,
  // one-cycle pulse per reference clock rising edge
  input wire ref_rise,
  // synchronised line sync, already made active high
  input wire line_sync,
  // programmed window
  input wire [`TVGL_HCNT_W-1:0] win_start,
  input wire [`TVGL_HCNT_W-1:0] win_end,
  // state
  output reg [`TVGL_HCNT_W-1:0] hcount,
  output reg hblank_n
);

  reg sync_prev;
  wire lead_edge;
  reg [`TVGL_HCNT_W-1:0] next_hcount;

  assign lead_edge = line_sync & ~sync_prev;

  // count restarts at the leading edge, saturates so a missing sync cannot wrap into the window
  always @* begin
    if (lead_edge)
      next_hcount = {`TVGL_HCNT_W{1'b0}};
    else if (hcount != `TVGL_HCNT_MAX)
      next_hcount = hcount + 11'h001;
    else
      next_hcount = hcount;
  end

  // everything advances only on reference clock cycles, never on the fast clock
  always @(posedge clock) begin
    if (!resetn) begin
      sync_prev <= 1'b0;
      hcount <= `TVGL_HCNT_MAX;
      hblank_n <= 1'b0;
    end else if (ref_rise) begin
      sync_prev <= line_sync;
      hcount <= next_hcount;
      if (next_hcount == win_end)
        hblank_n <= 1'b0;
      else if (next_hcount == win_start)
        hblank_n <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// [src/tvgl_top.v]
// tv-out genlock pixel port: apb registers, reference clock sampling, ddr pixel bus, blank
`timescale 1ns/10ps
`default_nettype none
`include "tvgl_defines.vh"

// Summary of operation
// - clock echo is a delayed copy of reference clock; pixel data leads it.
// - twelve-bit bus carries rising-edge half then falling-edge half of each pixel.
// - programmed window used only with format bits 16, 18 and ignore-timing set.
// - horizontal blank deasserts when count after line sync leading edge equals start.
// - horizontal blank reasserts when count after line sync leading edge equals end.
// - outgoing active-low blank is horizontal blank_n AND vertical blank_n.
// - window positions are counted in reference clock cycles from the encoder.
// - encoder reset output follows control bit 31, zero after reset.
module tvgl_top (
  // clock and reset
  input wire clock,
  input wire resetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`TVGL_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // pixel source and internal display timing
  input wire [23:0] pixel_rgb,
  input wire disp_hblank_n,
  input wire disp_vblank_n,
  output reg pixel_take,
  // encoder link
  input wire encoder_ref_clock_in,
  input wire encoder_line_sync,
  input wire encoder_frame_sync,
  output reg encoder_clock_echo,
  output reg [11:0] encoder_pixel_bus,
  output reg encoder_blank_strobe,
  output reg encoder_reset_out
);

  // registers
  reg [31:0] video_input_format_ctl;
  reg [31:0] tv_out_hblank_window;
  reg [31:0] tv_out_ctl;

  // synchronised link inputs
  wire [2:0] link_sync;
  wire ref_s;
  wire line_raw;
  wire frame_s;
  reg ref_d;
  wire ref_rise;
  wire ref_fall;
  wire line_active;

  // pixel path
  reg [23:0] pix_hold;
  reg [`TVGL_ECHO_DELAY_CYC-2:0] echo_pipe;

  // window state
  wire [`TVGL_HCNT_W-1:0] hcount;
  wire win_hblank_n;
  wire window_mode;
  wire hblank_sel_n;

  // apb decode
  wire apb_setup;
  wire apb_write;
  reg [31:0] next_prdata;
  reg next_pslverr;

  // true for any word this slave answers
  function addr_mapped;
    input [`TVGL_ADDR_W-1:0] a;
    begin
      addr_mapped = (a == `TVGL_OFS_FORMAT) || (a == `TVGL_OFS_HWIN) ||
                    (a == `TVGL_OFS_CTL) || (a == `TVGL_OFS_STATUS);
    end
  endfunction

  // rising-edge half: b0 b1 b2 g0 b3 b4 b5 b6 b7 g2 g3 g4 on bits 0 to 11
  function [11:0] rise_half;
    input [23:0] rgb;
    begin
      rise_half = {rgb[12], rgb[11], rgb[10], rgb[7], rgb[6], rgb[5], rgb[4],
                   rgb[3], rgb[8], rgb[2], rgb[1], rgb[0]};
    end
  endfunction

  // falling-edge half: g1 r0 r1 r2 g5 g6 g7 r3 r4 r5 r6 r7 on bits 0 to 11
  function [11:0] fall_half;
    input [23:0] rgb;
    begin
      fall_half = {rgb[23], rgb[22], rgb[21], rgb[20], rgb[19], rgb[15], rgb[14],
                   rgb[13], rgb[18], rgb[17], rgb[16], rgb[9]};
    end
  endfunction

  // status word read back by software
  function [31:0] status_word;
    input [`TVGL_HCNT_W-1:0] cnt;
    input hb_n;
    input wm;
    input ls;
    input fs;
    begin
      status_word = 32'h00000000;
      status_word[`TVGL_STS_HCOUNT_MSB:0] = cnt;
      status_word[`TVGL_STS_HBLANKN_BIT] = hb_n;
      status_word[`TVGL_STS_WINMODE_BIT] = wm;
      status_word[`TVGL_STS_LINESYNC_BIT] = ls;
      status_word[`TVGL_STS_FRAMESYNC_BIT] = fs;
    end
  endfunction

  // encoder pins are asynchronous to the core clock, so all pass two flops first
  tvgl_sync2 #(
    .W(3)
  ) u_link_sync (
    .clock(clock),
    .resetn(resetn),
    .async_in({encoder_frame_sync, encoder_line_sync, encoder_ref_clock_in}),
    .sync_out(link_sync)
  );

  assign ref_s = link_sync[0];
  assign line_raw = link_sync[1];
  assign frame_s = link_sync[2];

  // edge detection on the sampled reference clock
  always @(posedge clock) begin
    if (!resetn)
      ref_d <= 1'b0;
    else
      ref_d <= ref_s;
  end

  assign ref_rise = ref_s & ~ref_d;
  assign ref_fall = ~ref_s & ref_d;
  assign line_active = tv_out_ctl[`TVGL_CTL_SYNC_LOW_BIT] ? ~line_raw : line_raw;

  // window is honoured only in genlock with display timing overridden
  assign window_mode = video_input_format_ctl[`TVGL_FMT_TVOUT_BIT] &
                       video_input_format_ctl[`TVGL_FMT_GENLOCK_BIT] &
                       tv_out_ctl[`TVGL_CTL_IGNORE_TIMING_BIT];

  tvgl_hwin u_hwin (
    .clock(clock),
    .resetn(resetn),
    .ref_rise(ref_rise),
    .line_sync(line_active),
    .win_start(tv_out_hblank_window[`TVGL_WIN_START_MSB:`TVGL_WIN_START_LSB]),
    .win_end(tv_out_hblank_window[`TVGL_WIN_END_MSB:`TVGL_WIN_END_LSB]),
    .hcount(hcount),
    .hblank_n(win_hblank_n)
  );

  // selects the source, falls back to internal timing otherwise
  assign hblank_sel_n = window_mode ? win_hblank_n : disp_hblank_n;

  // clock echo lags the sampled reference clock by a fixed pipe; data moves one
  // core cycle after the sample, so it leads each echo edge by the pipe length
  always @(posedge clock) begin
    if (!resetn)
      echo_pipe <= {(`TVGL_ECHO_DELAY_CYC-1){1'b0}};
    else
      echo_pipe <= {echo_pipe[`TVGL_ECHO_DELAY_CYC-3:0], ref_s};
  end

  // last stage of the lag drives the pin from a flop of its own
  always @(posedge clock) begin
    if (!resetn)
      encoder_clock_echo <= 1'b0;
    else
      encoder_clock_echo <= echo_pipe[`TVGL_ECHO_DELAY_CYC-2];
  end

  // pixel captured on each reference rising edge; its falling half goes out later
  always @(posedge clock) begin
    if (!resetn)
      pix_hold <= 24'h000000;
    else if (ref_rise)
      pix_hold <= pixel_rgb;
  end

  // one-cycle strobe back to the pixel source, set on the same edge as the capture
  always @(posedge clock) begin
    if (!resetn)
      pixel_take <= 1'b0;
    else
      pixel_take <= ref_rise;
  end

  // ddr pixel bus: each half stands until the next opposite reference edge
  always @(posedge clock) begin
    if (!resetn)
      encoder_pixel_bus <= 12'h000;
    else if (ref_rise)
      encoder_pixel_bus <= rise_half(pixel_rgb);
    else if (ref_fall)
      encoder_pixel_bus <= fall_half(pix_hold);
  end

  // blank taken with the pixel so both change on the same reference edge
  always @(posedge clock) begin
    if (!resetn)
      encoder_blank_strobe <= 1'b0;
    else if (ref_rise)
      encoder_blank_strobe <= hblank_sel_n & disp_vblank_n;
  end

  // apb phases
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite & pready;

  // read mux worked out before the setup edge so prdata can be a plain flop
  always @* begin
    next_prdata = 32'h00000000;
    case (paddr)
      `TVGL_OFS_FORMAT: next_prdata = video_input_format_ctl;
      `TVGL_OFS_HWIN: next_prdata = tv_out_hblank_window;
      `TVGL_OFS_CTL: next_prdata = tv_out_ctl;
      `TVGL_OFS_STATUS: next_prdata = status_word(hcount, win_hblank_n, window_mode,
                                                   line_active, frame_s);
      default: next_prdata = 32'h00000000;
    endcase
  end

  // unmapped words and writes to the read-only status word are refused
  always @* begin
    next_pslverr = 1'b0;
    if (!addr_mapped(paddr))
      next_pslverr = 1'b1;
    else if (pwrite && (paddr == `TVGL_OFS_STATUS))
      next_pslverr = 1'b1;
  end

  // pready answers every setup one cycle later, so the bus never waits
  always @(posedge clock) begin
    if (!resetn)
      pready <= 1'b0;
    else
      pready <= apb_setup;
  end

  // error flag stands only together with pready
  always @(posedge clock) begin
    if (!resetn)
      pslverr <= 1'b0;
    else if (apb_setup)
      pslverr <= next_pslverr;
    else
      pslverr <= 1'b0;
  end

  // read data stands only in the access cycle, zero otherwise
  always @(posedge clock) begin
    if (!resetn)
      prdata <= 32'h00000000;
    else if (apb_setup)
      prdata <= next_prdata;
    else
      prdata <= 32'h00000000;
  end

  // format register; writes land on the completing access edge only
  always @(posedge clock) begin
    if (!resetn)
      video_input_format_ctl <= `TVGL_FORMAT_RST;
    else if (apb_write && (paddr == `TVGL_OFS_FORMAT))
      video_input_format_ctl <= pwdata;
  end

  // window register; end above start is software's duty, no check here
  always @(posedge clock) begin
    if (!resetn)
      tv_out_hblank_window <= `TVGL_HWIN_RST;
    else if (apb_write && (paddr == `TVGL_OFS_HWIN))
      tv_out_hblank_window <= pwdata & `TVGL_WIN_MASK;
  end

  // control register; reserved bits masked so they always read zero
  always @(posedge clock) begin
    if (!resetn)
      tv_out_ctl <= `TVGL_CTL_RST;
    else if (apb_write && (paddr == `TVGL_OFS_CTL))
      tv_out_ctl <= pwdata & `TVGL_CTL_MASK;
  end

  // encoder held in reset until software sets the bit; encoder setup itself
  // goes over the separate two-wire bus, not through this port
  always @(posedge clock) begin
    if (!resetn)
      encoder_reset_out <= 1'b0;
    else
      encoder_reset_out <= tv_out_ctl[`TVGL_CTL_ENC_RESETN_BIT];
  end

endmodule

`default_nettype wire

// [verification/tvgl_props.sv]
// checker for the tv-out genlock port, bound to its top module
`timescale 1ns/10ps
`default_nettype none
`include "tvgl_defines.vh"
module tvgl_props (
  // clock and reset
  input wire clock,
  input wire resetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`TVGL_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // pixel side
  input wire [23:0] pixel_rgb,
  input wire disp_vblank_n,
  input wire pixel_take,
  // encoder link
  input wire encoder_clock_echo,
  input wire [11:0] encoder_pixel_bus,
  input wire encoder_blank_strobe,
  input wire encoder_reset_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [23:0] pix_q;
  logic [5:0] vb_cnt;
  // pixel as it stood at the previous edge, the one the port captured
  always @(posedge clock) begin
    pix_q <= pixel_rgb;
  end
  // cycles of vertical blank held low; saturates so it never wraps back
  always @(posedge clock) begin
    if (!resetn || disp_vblank_n) vb_cnt <= 6'h00;
    else if (vb_cnt != 6'h3F) vb_cnt <= vb_cnt + 6'h01;
  end
  pready_once_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  bad_addr_a: assert property (pready && paddr[11:4] != 8'h00 |-> pslverr)
    else $error("unmapped access without error");
  enc_reset_a: assert property (
    psel && penable && pready && pwrite && paddr == `TVGL_OFS_CTL
    |=> ##1 encoder_reset_out == $past(pwdata[31], 2))
    else $error("encoder reset not from control bit");
  reset_zero_a: assert property (disable iff (1'b0) !resetn |=> !encoder_reset_out)
    else $error("encoder reset released by reset");
  bus_rise_a: assert property (pixel_take |-> encoder_pixel_bus ==
    {pix_q[12:10], pix_q[7:3], pix_q[8], pix_q[2:0]})
    else $error("rising half out of order");
  echo_follow_a: assert property (pixel_take |-> ##[1:4] $rose(encoder_clock_echo))
    else $error("clock echo does not follow data");
  vblank_gate_a: assert property (vb_cnt == 6'h28 |-> !encoder_blank_strobe)
    else $error("blank high during vertical blank");
  cover property (pixel_take);
  cover property (pready && pslverr);
  cover property ($rose(encoder_reset_out));
endmodule
bind tvgl_top tvgl_props chk_u (.*);
`default_nettype wire

// [verification/tvgl_enc_model.sv]
// encoder in master mode: free reference clock, line and frame sync
`timescale 1ns/10ps
`default_nettype none
module tvgl_enc_model (
  // reset from the port
  input wire logic enc_resetn,
  // timing driven to the port
  output logic ref_clk,
  output logic line_sync,
  output logic frame_sync
);
  int unsigned pos = 0;
  // video reference runs free; odd offset keeps its phase apart from the core clock
  initial begin
    ref_clk = 1'b0;
    #1.3;
    forever #32 ref_clk = ~ref_clk;
  end
  // 64 reference cycles per line, four lines per frame; idle while held in reset
  always @(posedge ref_clk) begin
    if (!enc_resetn) pos <= 0;
    else pos <= (pos + 1) % 256;
  end
  assign line_sync = enc_resetn && (pos % 64) < 4;
  assign frame_sync = enc_resetn && pos < 4;
  // mode setup would come over a separate two-wire bus, not modelled
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the tv-out genlock port
`timescale 1ns/10ps
`default_nettype none
`include "tvgl_defines.vh"
module tb_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [23:0] pixel_rgb = 24'h0;
  logic disp_hblank_n = 1'b1;
  logic disp_vblank_n = 1'b1;
  wire [31:0] prdata;
  wire [11:0] encoder_pixel_bus;
  wire pready, pslverr, pixel_take, encoder_ref_clock_in, encoder_line_sync;
  wire encoder_frame_sync, encoder_clock_echo, encoder_blank_strobe, encoder_reset_out;
  int err_count = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic er;
  always #2 clock = ~clock;
  tvgl_top dut_u (
    .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixel_rgb(pixel_rgb), .disp_hblank_n(disp_hblank_n), .disp_vblank_n(disp_vblank_n),
    .pixel_take(pixel_take), .encoder_ref_clock_in(encoder_ref_clock_in),
    .encoder_line_sync(encoder_line_sync), .encoder_frame_sync(encoder_frame_sync),
    .encoder_clock_echo(encoder_clock_echo), .encoder_pixel_bus(encoder_pixel_bus),
    .encoder_blank_strobe(encoder_blank_strobe), .encoder_reset_out(encoder_reset_out));
  tvgl_enc_model enc_u (.enc_resetn(encoder_reset_out), .ref_clk(encoder_ref_clock_in),
    .line_sync(encoder_line_sync), .frame_sync(encoder_frame_sync));
  task automatic end_sim;
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  // one apb transfer; a free edge first so psel is never set twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no answer time assumed; only the watchdog ends a hang
    do begin @(posedge clock); end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_take;
    do begin @(posedge clock); end while (pixel_take !== 1'b1);
  endtask
  task automatic t_regs;
    cmp("enc_reset", 32'h0, 32'(encoder_reset_out));
    apb(1'b0, `TVGL_OFS_CTL, 32'h0);
    cmp("ctl_rst", `TVGL_CTL_RST, rd);
    apb(1'b1, `TVGL_OFS_HWIN, 32'hFFFFFFFF);
    apb(1'b0, `TVGL_OFS_HWIN, 32'h0);
    cmp("hwin", `TVGL_WIN_MASK, rd);
    apb(1'b0, 12'h010, 32'h0);
    cmp("bad_err", 32'h1, 32'(er));
    apb(1'b1, `TVGL_OFS_CTL, 32'h80000000);
    // the pin flop follows the register one edge later; look once it has settled
    repeat (2) @(posedge clock);
    cmp("enc_reset", 32'h1, 32'(encoder_reset_out));
  endtask
  task automatic t_pixel;
    pixel_rgb <= 24'hA5C33C;
    wait_take;
    wait_take;
    cmp("rise_half", 32'h07C, 32'(encoder_pixel_bus));
    cmp("echo_lag", 32'h0, 32'(encoder_clock_echo));
    repeat (3) @(posedge clock);
    cmp("echo_rise", 32'h1, 32'(encoder_clock_echo));
    do begin @(posedge clock); end while (encoder_pixel_bus === 12'h07C);
    cmp("fall_half", 32'hA6B, 32'(encoder_pixel_bus));
  endtask
  task automatic t_window;
    logic [10:0] mx;
    logic [10:0] c;
    logic ok;
    mx = 11'h000;
    ok = 1'b0;
    apb(1'b1, `TVGL_OFS_FORMAT, 32'h00050000);
    apb(1'b1, `TVGL_OFS_HWIN, 32'h00140008);
    apb(1'b1, `TVGL_OFS_CTL, 32'h80000001);
    repeat (700) begin
      apb(1'b0, `TVGL_OFS_STATUS, 32'h0);
      c = rd[10:0];
      if (c != 11'h7FF && c > mx) mx = c;
      // a line already past its start when the window was written is not judged
      if (c < 11'h008) ok = 1'b1;
      if (ok && (c < 11'h008 || c > 11'h014)) cmp("hblank", 32'h0, 32'(rd[16]));
      else if (ok && c > 11'h008 && c < 11'h014) cmp("hblank", 32'h1, 32'(rd[16]));
    end
    cmp("win_mode", 32'h1, 32'(rd[17]));
    cmp("line_len", 32'h3F, 32'(mx));
    disp_vblank_n <= 1'b0;
    repeat (40) @(posedge clock);
    cmp("blank_v", 32'h0, 32'(encoder_blank_strobe));
    disp_vblank_n <= 1'b1;
  endtask
  // active-low line sync: mid-line the inverted sync reads back as active
  task automatic t_pol;
    apb(1'b1, `TVGL_OFS_CTL, 32'h80000003);
    do begin apb(1'b0, `TVGL_OFS_STATUS, 32'h0); end while (rd[10:0] != 11'h030);
    do begin apb(1'b0, `TVGL_OFS_STATUS, 32'h0); end while (rd[10:0] != 11'h020);
    cmp("sync_low", 32'h1, 32'(rd[18]));
    apb(1'b1, `TVGL_OFS_CTL, 32'h80000001);
    do begin apb(1'b0, `TVGL_OFS_STATUS, 32'h0); end while (rd[10:0] != 11'h020);
    cmp("sync_high", 32'h0, 32'(rd[18]));
  endtask
  // genlock bit clear, then ignore-timing clear: the internal timing must drive the blank
  task automatic t_disp;
    apb(1'b1, `TVGL_OFS_FORMAT, 32'h00010000);
    apb(1'b0, `TVGL_OFS_STATUS, 32'h0);
    cmp("win_mode", 32'h0, 32'(rd[17]));
    apb(1'b1, `TVGL_OFS_FORMAT, 32'h00050000);
    apb(1'b1, `TVGL_OFS_CTL, 32'h80000000);
    apb(1'b0, `TVGL_OFS_STATUS, 32'h0);
    cmp("win_mode_ign", 32'h0, 32'(rd[17]));
    disp_hblank_n <= 1'b0;
    repeat (40) @(posedge clock);
    cmp("blank_h", 32'h0, 32'(encoder_blank_strobe));
    disp_hblank_n <= 1'b1;
    repeat (40) @(posedge clock);
    cmp("blank_h", 32'h1, 32'(encoder_blank_strobe));
  endtask
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    t_regs;
    t_pixel;
    t_window;
    t_pol;
    t_disp;
    end_sim;
  end
  // the full run needs about 20 us
  initial begin
    #100000;
    err_count++;
    end_sim;
  end
endmodule
`default_nettype wire
